/* hw/sabp_pkg.sv */
/*
  Constants shared by the sign brightness controller: clock rate, PWM
  timing, register offsets, field positions and reset values.
  Assumes a 125 MHz system clock and a 32-bit plain register port.
*/
package sabp_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ    = 125_000_000; // System clock rate.
  localparam int unsigned PWM_STEPS = 10000;       // Steps per PWM period.
  localparam int unsigned NIGHT_HZ  = 100;         // Night PWM frequency.
  localparam int unsigned DAY_HZ    = 2000;        // Day PWM frequency.
  // Clocks per PWM step; rounding down only raises the frequency.
  localparam logic [7:0] NIGHT_DIV = 8'(CLK_HZ / (NIGHT_HZ * PWM_STEPS));
  localparam logic [7:0] DAY_DIV   = 8'(CLK_HZ / (DAY_HZ * PWM_STEPS));
  localparam logic [13:0] PERIOD_LAST = 14'(PWM_STEPS - 1);
  // Photocell sample interval in microseconds and in clocks.
  localparam int unsigned SAMPLE_US  = 1000;
  localparam int unsigned SAMPLE_CYC = CLK_HZ / 1_000_000 * SAMPLE_US;

  // ---------------------------------------------------------------
  // Duty limits, in steps of 0.01 percent
  // ---------------------------------------------------------------
  localparam logic [13:0] DUTY_MIN     = 14'h0003; // 0.03 percent.
  localparam logic [13:0] DUTY_MAX     = 14'h2706; // 99.9 percent.
  localparam logic [13:0] DUTY_PER_PCT = 14'h0064; // One percent.
  localparam logic [13:0] LIN_SLOPE    = 14'h0027; // Fallback table slope.
  localparam logic [6:0]  PCT_MIN      = 7'h01;
  localparam logic [6:0]  PCT_MAX      = 7'h63;

  // ---------------------------------------------------------------
  // Register offsets and fields
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CTRL    = 4'h0; // Manual and table enable.
  localparam logic [3:0] REG_MANUAL  = 4'h1; // Manual percentage.
  localparam logic [3:0] REG_THRESH  = 4'h2; // Day/night threshold.
  localparam logic [3:0] REG_RATE_D  = 4'h3; // Day response rate.
  localparam logic [3:0] REG_RATE_N  = 4'h4; // Night response rate.
  localparam logic [3:0] REG_WEIGHT  = 4'h5; // Photocell weights.
  localparam logic [3:0] REG_STATUS  = 4'h6; // Live state, read only.
  localparam logic [3:0] REG_TBL_ADR = 4'h7; // Table write address.
  localparam logic [3:0] REG_TBL_DAT = 4'h8; // Table entry data.
  localparam int unsigned CTRL_MAN_BIT = 0;
  localparam int unsigned CTRL_TBL_BIT = 1;
  localparam int unsigned ST_NIGHT_BIT = 8;
  localparam int unsigned ST_MAN_BIT   = 9;
  localparam int unsigned ST_DUTY_LSB  = 16;
  // Positions in the synchroniser vector.
  localparam int unsigned SY_FRONT = 0;
  localparam int unsigned SY_REAR  = 8;
  localparam int unsigned SY_AMB   = 16;
  localparam int unsigned SY_PCT   = 24;
  localparam int unsigned SY_MAN   = 31;
  localparam int unsigned SY_AUTO  = 32;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_THRESH = 8'h40;
  localparam logic [7:0]  RST_RATE_D = 8'h04;
  localparam logic [7:0]  RST_RATE_N = 8'h10;
  localparam logic [23:0] RST_WEIGHT = 24'h555555;
  localparam logic [6:0]  RST_PCT    = 7'h32;

endpackage

/* hw/sabp_pwm.sv */
/*
  Pulse-width modulator for the pixel string current.
  Assumes duty arrives already clamped; it is taken only at period start.
*/
`timescale 1ns/1ps
`default_nettype none
module sabp_pwm
  import sabp_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Requested duty and frequency band.
  input  wire logic [13:0] duty,
  input  wire logic        night,
  // Modulated enable of the string current.
  output logic             pwm_o
);

  typedef struct packed {
    logic [7:0]  div_cnt; // Clocks left in this step.
    logic [13:0] step;    // Position within the period.
    logic [13:0] duty_l;  // Duty held for the whole period.
    logic        night_l; // Band held for the whole period.
    logic        pwm;     // Registered output.
  } sabp_pwm_t;

  sabp_pwm_t s_r;
  sabp_pwm_t s_nxt;
  logic      wrap;

  // Advance the step counter; latch duty and band only at the wrap so
  // that a period never carries a torn pulse.
  always_comb begin
    s_nxt = s_r;
    wrap  = 1'b0;
    if (s_r.div_cnt == 8'h00) begin
      s_nxt.div_cnt = (s_r.night_l ? NIGHT_DIV : DAY_DIV) - 8'h01;
      if (s_r.step == PERIOD_LAST) begin
        wrap          = 1'b1;
        s_nxt.step    = 14'h0000;
        s_nxt.duty_l  = duty;
        s_nxt.night_l = night;
        // The first step of a new period already runs at the new band.
        s_nxt.div_cnt = (night ? NIGHT_DIV : DAY_DIV) - 8'h01;
      end else begin
        s_nxt.step = s_r.step + 14'h0001;
      end
    end else begin
      s_nxt.div_cnt = s_r.div_cnt - 8'h01;
    end
    s_nxt.pwm = s_nxt.step < s_nxt.duty_l;
  end

  // State register.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pwm_o = s_r.pwm;

  property p_latch;
    @(posedge clk) disable iff (!rst_n)
    wrap |=> (s_r.duty_l == $past(duty)) && (s_r.night_l == $past(night));
  endproperty
  a_latch: assert property (p_latch) else $error("duty not latched");

endmodule
`default_nettype wire

/* hw/sabp_slew.sv */
/*
  Response-rate filter: moves the brightness level one step at a time
  toward the target. Assumes tick is a one-cycle sample strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module sabp_slew
  import sabp_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Sample strobe, target, active rate and band.
  input  wire logic       tick,
  input  wire logic [7:0] target,
  input  wire logic [7:0] rate,
  input  wire logic       night,
  // Filtered level.
  output logic [7:0]      level
);

  typedef struct packed {
    logic [7:0] level; // Current level.
    logic [9:0] cnt;   // Samples the target has stood on one side.
    logic       up;    // Direction being counted.
  } sabp_slew_t;

  sabp_slew_t s_r;
  sabp_slew_t s_nxt;
  logic       dir;
  logic [9:0] limit;

  // A step is taken only after the target has held one direction for
  // the rate; at night brightening waits four times longer so that a
  // passing headlight dies away before the sign reacts.
  always_comb begin
    s_nxt = s_r;
    dir   = target > s_r.level;
    limit = (night && dir) ? {rate, 2'b00} : {2'b00, rate};
    if (tick) begin
      if (target == s_r.level || dir != s_r.up) begin
        s_nxt.cnt = 10'h000;
        s_nxt.up  = dir;
      end else if (s_r.cnt >= limit) begin
        s_nxt.cnt   = 10'h000;
        s_nxt.level = dir ? s_r.level + 8'h01 : s_r.level - 8'h01;
      end else begin
        s_nxt.cnt = s_r.cnt + 10'h001;
      end
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign level = s_r.level;

  property p_one_step;
    @(posedge clk) disable iff (!rst_n)
    (s_r.level != $past(s_r.level)) |->
      $past(tick) && ((s_r.level - $past(s_r.level) == 8'h01) ||
                      ($past(s_r.level) - s_r.level == 8'h01));
  endproperty
  a_one_step: assert property (p_one_step) else $error("level jump");

  property p_night_up;
    @(posedge clk) disable iff (!rst_n)
    (s_r.level == $past(s_r.level) + 8'h01) && $past(night) |->
      $past(s_r.cnt) >= {$past(rate), 2'b00};
  endproperty
  a_night_up: assert property (p_night_up) else $error("fast rise");

endmodule
`default_nettype wire

/* hw/sabp_top.sv */
/*
  Automatic and manual brightness control for an LED message sign.
  Samples three photocells, weights them, decides day or night,
  filters the level, maps it through a downloadable table and drives
  the PWM of the string current. Assumes photocell codes and front
  panel buttons arrive asynchronously on pins, and that software uses
  the plain register port with read data one cycle after the strobe.
*/
// Behaviour
// - PWM current, 100 Hz night, over 1600 day
// - Duty 0.03 to 99.9 percent, fine steps
// - Lookup table of at least 256 levels
// - Table per sign, replaceable by download
// - Three photocells: front, rear, ambient
// - Continuously convert light into target level
// - Automatic changes move one adjacent level
// - Suppress night brightening from brief headlights
// - Remote rates for day, night, plus threshold
// - Per-photocell weights for night ambient value
// - Manual brightness 1 to 99 percent
// - Panel or remote cancels manual mode
`timescale 1ns/1ps
`default_nettype none
module sabp_top
  import sabp_pkg::*;
#(
  parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYC
)
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port.
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic [31:0]      rd_data,
  // Photocell codes from the converters.
  input  wire logic [7:0]  photo_front,
  input  wire logic [7:0]  photo_rear,
  input  wire logic [7:0]  photo_amb,
  // Front panel controls.
  input  wire logic [6:0]  panel_pct,
  input  wire logic        panel_manual,
  input  wire logic        panel_auto,
  // Drive and status.
  output logic             pwm_out,
  output logic             night_o,
  output logic             manual_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [32:0] s1;         // First synchroniser stage.
    logic [32:0] s2;         // Second synchroniser stage.
    logic [1:0]  btn_prev;   // Button history for edge detection.
    logic [16:0] samp_cnt;   // Sample interval counter.
    logic        tick;       // One-cycle sample strobe.
    logic        manual;     // Manual brightness active.
    logic        tbl_en;     // Use the downloaded table.
    logic [6:0]  pct;        // Manual percentage.
    logic [7:0]  thresh;     // Day/night threshold.
    logic [7:0]  rate_day;   // Day response rate.
    logic [7:0]  rate_night; // Night response rate.
    logic [23:0] weights;    // Front, rear, ambient weights.
    logic [7:0]  tbl_addr;   // Table download pointer.
    logic        night;      // Current band.
    logic [7:0]  target;     // Level wanted by the photocells.
    logic [13:0] duty;       // Duty sent to the modulator.
    logic [31:0] rd_data;    // Registered read answer.
  } sabp_state_t;

  localparam sabp_state_t RST_STATE = '{
    s1: '0, s2: '0, btn_prev: '0, samp_cnt: '0, tick: 1'b0,
    manual: 1'b0, tbl_en: 1'b0, pct: RST_PCT, thresh: RST_THRESH,
    rate_day: RST_RATE_D, rate_night: RST_RATE_N, weights: RST_WEIGHT,
    tbl_addr: '0, night: 1'b0, target: '0, duty: DUTY_MIN,
    rd_data: '0
  };

  sabp_state_t s_r;            // Registered state.
  sabp_state_t s_nxt;          // Next state.
  logic [7:0]  level;          // Filtered level.
  logic [13:0] tbl_q;          // Table entry for the level.
  logic [13:0] tbl_mem [0:255]; // Downloadable brightness table.
  logic        tbl_we;         // Table entry write.
  logic [17:0] wsum;           // Weighted photocell sum.
  logic [7:0]  wsat;           // Weighted value, saturated.
  logic [13:0] auto_duty;      // Duty from automatic control.
  logic [13:0] man_duty;       // Duty from manual control.
  logic [13:0] raw_duty;       // Duty before clamping.
  logic [7:0]  rate_sel;       // Rate for the current band.
  logic        man_edge;       // Panel manual press.
  logic        auto_edge;      // Panel auto press.

  // ---------------------------------------------------------------
  // Clamp a requested manual percentage into range
  // ---------------------------------------------------------------
  function automatic logic [6:0] clamp_pct(input logic [6:0] p);
    if (p < PCT_MIN) begin
      return PCT_MIN;
    end else if (p > PCT_MAX) begin
      return PCT_MAX;
    end
    return p;
  endfunction

  // ---------------------------------------------------------------
  // Brightness table
  // ---------------------------------------------------------------
  assign tbl_we = wr_en && (addr == REG_TBL_DAT);

  // Entries are written through the pointer and read by the level.
  // Contents are undefined until downloaded, so the table stays out of
  // use until software sets the enable.
  always_ff @(posedge clk) begin
    if (tbl_we) begin
      tbl_mem[s_r.tbl_addr] <= wr_data[13:0];
    end
    tbl_q <= tbl_mem[level];
  end

  // ---------------------------------------------------------------
  // Combinational next state
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    // Pins pass two flip-flops before any logic reads them. A code may
    // tear for one sample while its bits settle; the filter absorbs it.
    s_nxt.s1 = {panel_auto, panel_manual, panel_pct,
                photo_amb, photo_rear, photo_front};
    s_nxt.s2 = s_r.s1;
    s_nxt.btn_prev = {s_r.s2[SY_AUTO], s_r.s2[SY_MAN]};
    man_edge  = s_r.s2[SY_MAN] && !s_r.btn_prev[0];
    auto_edge = s_r.s2[SY_AUTO] && !s_r.btn_prev[1];

    // Free-running sample strobe keeps the photocells watched.
    if (s_r.samp_cnt >= 17'(SAMPLE_CYCLES - 1)) begin
      s_nxt.samp_cnt = 17'h00000;
      s_nxt.tick     = 1'b1;
    end else begin
      s_nxt.samp_cnt = s_r.samp_cnt + 17'h00001;
      s_nxt.tick     = 1'b0;
    end

    // Weighted ambient value from the three cells, scaled by 1/256.
    wsum = 18'(s_r.weights[7:0] * s_r.s2[SY_FRONT +: 8])
         + 18'(s_r.weights[15:8] * s_r.s2[SY_REAR +: 8])
         + 18'(s_r.weights[23:16] * s_r.s2[SY_AMB +: 8]);
    wsat = (wsum[17:16] != 2'b00) ? 8'hFF : wsum[15:8];

    // On each sample, decide the band and the target level. By night
    // the weighted value indexes the table, by day the ambient cell.
    if (s_r.tick) begin
      s_nxt.night  = wsat < s_r.thresh;
      s_nxt.target = (wsat < s_r.thresh) ? wsat
                                         : s_r.s2[SY_AMB +: 8];
    end

    // Register writes from the remote party.
    if (wr_en) begin
      unique case (addr)
        REG_CTRL: begin
          s_nxt.manual = wr_data[CTRL_MAN_BIT];
          s_nxt.tbl_en = wr_data[CTRL_TBL_BIT];
        end
        REG_MANUAL:  s_nxt.pct = clamp_pct(wr_data[6:0]);
        REG_THRESH:  s_nxt.thresh = wr_data[7:0];
        REG_RATE_D:  s_nxt.rate_day = wr_data[7:0];
        REG_RATE_N:  s_nxt.rate_night = wr_data[7:0];
        REG_WEIGHT:  s_nxt.weights = wr_data[23:0];
        REG_TBL_ADR: s_nxt.tbl_addr = wr_data[7:0];
        REG_TBL_DAT: s_nxt.tbl_addr = s_r.tbl_addr + 8'h01;
        default: begin
          // Unmapped and read-only offsets ignore writes.
        end
      endcase
    end

    // Front panel presses act after remote writes in the same cycle.
    if (man_edge) begin
      s_nxt.manual = 1'b1;
      s_nxt.pct    = clamp_pct(s_r.s2[SY_PCT +: 7]);
    end
    if (auto_edge) begin
      s_nxt.manual = 1'b0;
    end

    // Duty selection: manual overrides the photocell path entirely.
    // The filter keeps tracking meanwhile, so a return to automatic
    // resumes from the present light and not from a stale level.
    auto_duty = s_r.tbl_en ? tbl_q : 14'(level) * LIN_SLOPE + DUTY_MIN;
    man_duty  = 14'(s_r.pct) * DUTY_PER_PCT;
    raw_duty  = s_r.manual ? man_duty : auto_duty;
    // A table entry outside the legal duty span is pulled back into it.
    if (raw_duty < DUTY_MIN) begin
      s_nxt.duty = DUTY_MIN;
    end else if (raw_duty > DUTY_MAX) begin
      s_nxt.duty = DUTY_MAX;
    end else begin
      s_nxt.duty = raw_duty;
    end

    // Registered read answer; zero when no read was made.
    s_nxt.rd_data = 32'h00000000;
    if (rd_en) begin
      unique case (addr)
        REG_CTRL: begin
          s_nxt.rd_data[CTRL_MAN_BIT] = s_r.manual;
          s_nxt.rd_data[CTRL_TBL_BIT] = s_r.tbl_en;
        end
        REG_MANUAL:  s_nxt.rd_data[6:0] = s_r.pct;
        REG_THRESH:  s_nxt.rd_data[7:0] = s_r.thresh;
        REG_RATE_D:  s_nxt.rd_data[7:0] = s_r.rate_day;
        REG_RATE_N:  s_nxt.rd_data[7:0] = s_r.rate_night;
        REG_WEIGHT:  s_nxt.rd_data[23:0] = s_r.weights;
        REG_STATUS: begin
          s_nxt.rd_data[7:0]                = level;
          s_nxt.rd_data[ST_NIGHT_BIT]       = s_r.night;
          s_nxt.rd_data[ST_MAN_BIT]         = s_r.manual;
          s_nxt.rd_data[ST_DUTY_LSB +: 14]  = s_r.duty;
        end
        REG_TBL_ADR: s_nxt.rd_data[7:0] = s_r.tbl_addr;
        default: begin
          // Unmapped offsets and table data read as zero.
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= RST_STATE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Filter and modulator
  // ---------------------------------------------------------------
  // The band decided on the last sample picks the response rate.
  assign rate_sel = s_r.night ? s_r.rate_night : s_r.rate_day;

  // Level follows the target no faster than the active rate.
  sabp_slew u_slew (
    .clk    (clk),
    .rst_n  (rst_n),
    .tick   (s_r.tick),
    .target (s_r.target),
    .rate   (rate_sel),
    .night  (s_r.night),
    .level  (level)
  );

  // The band picks the PWM frequency.
  sabp_pwm u_pwm (
    .clk   (clk),
    .rst_n (rst_n),
    .duty  (s_r.duty),
    .night (s_r.night),
    .pwm_o (pwm_out)
  );

  assign rd_data  = s_r.rd_data;
  assign night_o  = s_r.night;
  assign manual_o = s_r.manual;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_duty_range;
    @(posedge clk) disable iff (!rst_n)
    (s_r.duty >= DUTY_MIN) && (s_r.duty <= DUTY_MAX);
  endproperty
  a_duty_range: assert property (p_duty_range) else $error("duty range");

  property p_manual_hold;
    @(posedge clk) disable iff (!rst_n)
    $past(s_r.manual) |->
      s_r.duty == 14'($past(s_r.pct)) * DUTY_PER_PCT;
  endproperty
  a_manual_hold: assert property (p_manual_hold) else $error("manual");

  property p_panel_set;
    @(posedge clk) disable iff (!rst_n)
    (s_r.s2[SY_MAN] && !s_r.btn_prev[0] && !s_r.s2[SY_AUTO]) |=>
      s_r.manual && (s_r.pct >= PCT_MIN) && (s_r.pct <= PCT_MAX);
  endproperty
  a_panel_set: assert property (p_panel_set) else $error("panel set");

  property p_panel_cancel;
    @(posedge clk) disable iff (!rst_n)
    (s_r.s2[SY_AUTO] && !s_r.btn_prev[1]) |=> !s_r.manual;
  endproperty
  a_panel_cancel: assert property (p_panel_cancel) else $error("cancel");

  property p_band;
    @(posedge clk) disable iff (!rst_n)
    s_r.tick |=> s_r.night == ($past(wsat) < $past(s_r.thresh));
  endproperty
  a_band: assert property (p_band) else $error("band");

  property p_tbl_ptr;
    @(posedge clk) disable iff (!rst_n)
    tbl_we |=> s_r.tbl_addr == $past(s_r.tbl_addr) + 8'h01;
  endproperty
  a_tbl_ptr: assert property (p_tbl_ptr) else $error("table pointer");

  property p_rate_rd;
    @(posedge clk) disable iff (!rst_n)
    (rd_en && addr == REG_RATE_N) |=>
      rd_data == {24'h000000, $past(s_r.rate_night)};
  endproperty
  a_rate_rd: assert property (p_rate_rd) else $error("rate read");

  // Each sample turns the light reading into a fresh target level.
  property p_target;
    @(posedge clk) disable iff (!rst_n)
    s_r.tick |=> s_r.target == (($past(wsat) < $past(s_r.thresh)) ?
                                $past(wsat) : $past(s_r.s2[SY_AMB +: 8]));
  endproperty
  a_target: assert property (p_target) else $error("target");

  // With the table in use, an entry inside the duty span is sent as is.
  property p_table;
    @(posedge clk) disable iff (!rst_n)
    (s_r.tbl_en && !s_r.manual &&
     (tbl_q >= DUTY_MIN) && (tbl_q <= DUTY_MAX)) |=>
      s_r.duty == $past(tbl_q);
  endproperty
  a_table: assert property (p_table) else $error("table entry");

  // A read answer stands for one cycle only and is zero otherwise.
  property p_rd_idle;
    @(posedge clk) disable iff (!rst_n)
    !rd_en |=> rd_data == 32'h00000000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read idle");

endmodule
`default_nettype wire

/* verification/sabp_photo_model.sv */
/*
  Photocell front end: three converter codes and a headlight strobe.
  Assumes the bench sets the light level of each cell.
*/
`timescale 1ns/1ps
`default_nettype none
module sabp_photo_model (
  // Clock.
  input  wire logic       clk,
  // Light at each cell and a headlight strobe.
  input  wire logic [7:0] lux_front,
  input  wire logic [7:0] lux_rear,
  input  wire logic [7:0] lux_amb,
  input  wire logic       glare,
  // Converter codes.
  output logic      [7:0] code_front,
  output logic      [7:0] code_rear,
  output logic      [7:0] code_amb
);
  // Headlights saturate the front cell only while the strobe is high.
  always_ff @(posedge clk) begin
    code_front <= glare ? 8'hFF : lux_front;
    code_rear  <= lux_rear;
    code_amb   <= lux_amb;
  end
endmodule
`default_nettype wire

/* verification/tb_sabp_top.sv */
/*
  Self-checking bench: register port, manual modes, day and night,
  weighting, glare and table download. Assumes the package and the
  photocell model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_sabp_top;
  import sabp_pkg::*;
  localparam int unsigned SC = 16; // Short sample interval.
  logic        clk, rst_n, wr_en, rd_en, glare;
  logic [3:0]  addr;
  logic [31:0] wr_data, rd_data, v, w;
  logic [7:0]  pf, pr, pa, lf, lr, la;
  logic [6:0]  panel_pct;
  logic        panel_manual, panel_auto, pwm_out, night_o, manual_o;
  int          err_count, checks_done, n;
  logic [2:0]  outs; // Watched outputs, picked by index.
  localparam int W_PWM = 0, W_NIGHT = 1, W_MAN = 2;
  assign outs = {manual_o, night_o, pwm_out};

  sabp_top #(.SAMPLE_CYCLES(SC)) sabp_top_i (.clk(clk), .rst_n(rst_n),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .photo_front(pf), .photo_rear(pr),
    .photo_amb(pa), .panel_pct(panel_pct), .panel_manual(panel_manual),
    .panel_auto(panel_auto), .pwm_out(pwm_out), .night_o(night_o),
    .manual_o(manual_o));
  sabp_photo_model sabp_photo_model_i (.clk(clk), .lux_front(lf),
    .lux_rear(lr), .lux_amb(la), .glare(glare), .code_front(pf),
    .code_rear(pr), .code_amb(pa));

  // Free-running 125 MHz clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Counts a comparison and reports a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // One-cycle register write.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  // One-cycle register read; data stand in the following cycle.
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    d = rd_data;
    @(posedge clk);
  endtask
  task automatic rc(input logic [3:0] a, input logic [31:0] e);
    rd(a, v);
    chk(v, e);
  endtask
  // Bounded wait for a design output to reach a level.
  task automatic wait_sig(input int b, input logic lvl, input int lim);
    n = 0;
    @(negedge clk);
    while (outs[b] !== lvl && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk({31'h0, outs[b]}, {31'h0, lvl});
    @(posedge clk);
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Watchdog against a hang.
  initial begin
    repeat (95000) @(posedge clk);
    err_count++;
    end_of_test();
  end

  // Main sequence.
  initial begin
    {rst_n, addr, wr_data, wr_en, rd_en, glare} = '0;
    {panel_pct, panel_manual, panel_auto} = '0;
    {lf, lr, la} = {8'hC8, 8'hC8, 8'hC8};
    err_count = 0;
    checks_done = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk({29'h0, pwm_out, night_o, manual_o}, 32'h0);
    rc(REG_CTRL, 32'h0);
    rc(REG_MANUAL, 32'(RST_PCT));
    rc(REG_THRESH, 32'(RST_THRESH));
    rc(REG_RATE_D, 32'(RST_RATE_D));
    rc(REG_RATE_N, 32'(RST_RATE_N));
    rc(REG_WEIGHT, 32'(RST_WEIGHT));
    rc(4'h9, 32'h0);
    rc(REG_TBL_DAT, 32'h0);
    @(posedge clk);
    #1;
    chk(rd_data, 32'h0);
    $display("test reset done");
    // Remote manual 20 percent: duty and pulse width by day.
    wr(REG_MANUAL, 32'h14);
    wr(REG_CTRL, 32'h1);
    repeat (10) @(posedge clk);
    rd(REG_STATUS, v);
    chk(32'(v[29:16]), 32'(14'h14 * DUTY_PER_PCT));
    chk(32'(v[ST_MAN_BIT]), 32'h1);
    wait_sig(W_PWM, 1'b0, 70000);
    wait_sig(W_PWM, 1'b1, 70000);
    n = 0;
    while (pwm_out === 1'b1 && n < 70000) begin
      @(negedge clk);
      n++;
    end
    chk(32'(n), 32'(2000 * DAY_DIV));
    wr(REG_MANUAL, 32'h0);
    rc(REG_MANUAL, 32'(PCT_MIN));
    wr(REG_MANUAL, 32'h64);
    rc(REG_MANUAL, 32'(PCT_MAX));
    wr(REG_CTRL, 32'h0);
    repeat (3) @(posedge clk);
    chk({31'h0, manual_o}, 32'h0);
    $display("test remote manual done");
    // Panel manual 30 percent holds while light changes, then auto.
    panel_pct <= 7'h1E;
    panel_manual <= 1'b1;
    wait_sig(W_MAN, 1'b1, 10);
    panel_manual <= 1'b0;
    {lf, lr, la} <= {8'h0A, 8'h0A, 8'h0A};
    repeat (10 * SC) @(posedge clk);
    rd(REG_STATUS, v);
    chk(32'(v[29:16]), 32'h0BB8);
    panel_auto <= 1'b1;
    wait_sig(W_MAN, 1'b0, 10);
    panel_auto <= 1'b0;
    $display("test panel done");
    // Weighting decides the band: front only is dark, ambient is bright.
    {lf, lr, la} <= {8'h00, 8'hFF, 8'hFF};
    wait_sig(W_NIGHT, 1'b0, 8 * SC);
    wr(REG_WEIGHT, 32'h0000FF);
    wait_sig(W_NIGHT, 1'b1, 8 * SC);
    wr(REG_WEIGHT, 32'hFF0000);
    wait_sig(W_NIGHT, 1'b0, 8 * SC);
    $display("test weighting done");
    // Headlights at night must not brighten the sign.
    wr(REG_WEIGHT, 32'(RST_WEIGHT));
    wr(REG_THRESH, 32'hFF);
    wr(REG_RATE_N, 32'h01);
    {lf, lr, la} <= {8'h00, 8'h00, 8'h00};
    wait_sig(W_NIGHT, 1'b1, 8 * SC);
    // Fall below the level that a headlit front cell asks for.
    repeat (7000) @(posedge clk);
    rd(REG_STATUS, w);
    chk(32'(w[7:0] < 8'h54), 32'h1);
    glare <= 1'b1;
    repeat (5 * SC) @(posedge clk);
    glare <= 1'b0;
    rd(REG_STATUS, v);
    chk(32'(v[7:0] <= w[7:0]), 32'h1);
    $display("test glare done");
    // Downloaded table of 256 levels replaces the fallback mapping.
    wr(REG_TBL_ADR, 32'h0);
    for (int i = 0; i < 256; i++) begin
      wr(REG_TBL_DAT, 32'h1388);
    end
    wr(REG_CTRL, 32'h2);
    repeat (8) @(posedge clk);
    rd(REG_STATUS, v);
    chk(32'(v[29:16]), 32'h1388);
    $display("test table done");
    end_of_test();
  end
endmodule
`default_nettype wire
